// >>> bus_port_pkg.sv
// Shared constants and carriers for the backplane master port
//
// Contract
// [RULE1] Transfer type is coded read 00, word write 10, byte write 11 on the two control lines.
// [RULE2] The owning unit holds bus-busy asserted for the whole time it uses the bus.
// [RULE3] A granted unit starts no transfer until it sees bus-busy released.
// [RULE4] The port raises the non-processor request when it needs the bus for direct memory moves.
// [RULE5] The interrupt line is raised only while bus master, with the vector on the data lines.
// [RULE6] On a non-processor grant or bus grant the port raises selection acknowledge.
// [RULE7] The first drive's vector is 224 octal, or 274 octal when the alternate jumper is set.
// [RULE8] Other drives take their vector from a switch setting of their own.
// [RULE9] Interrupts are requested at the jumper-chosen priority level, level 5 by default.
// [RULE10] An interrupt is raised on operation complete and on error.
// [RULE11] The master asserts master sync while address and control are valid.
// [RULE12] The slave answers master sync or interrupt with slave sync to close each step.
// [RULE13] Addresses are 18 bits wide and data moves over the 16 data lines.
// [RULE14] Backplane lines are active-low wired-OR: pulled low to assert, released otherwise.
// [RULE15] Request drops once selection acknowledge is up; acknowledge drops after bus-busy is taken; the port drops it on the same clock it takes bus-busy.
package bus_port_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 16;
	localparam logic [1:0] XFER_READ = 2'h0;
	localparam logic [1:0] XFER_WRITE = 2'h2;
	localparam logic [1:0] XFER_WRITE_BYTE = 2'h3;
	localparam logic [8:0] VEC_FIRST = 9'h094;
	localparam logic [8:0] VEC_FIRST_ALT = 9'h0bc;
	localparam logic [2:0] PRIO_DEFAULT = 3'h5;
	localparam int SETTLE_NS = 75;
	localparam int CLK_MHZ = 40;
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int SYNC_TIMEOUT_CYC = 400;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [1:0] xfer;
	} xfer_req_t;

	typedef struct packed {
		logic done;
		logic error;
		logic [1:0] drive;
	} event_t;
endpackage

// >>> word_fifo.sv
// Synchronous FIFO between the tape side and the bus master
`timescale 1ns/10ps
module word_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("word_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_r;
	logic [AW:0] rd_r;
	logic push;
	logic pop;

	assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
	assign out_valid = wr_r != rd_r;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_r[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_r[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			wr_r <= '0;
		else if (push)
			wr_r <= wr_r + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			rd_r <= '0;
		else if (pop)
			rd_r <= rd_r + 1'b1;
	end
endmodule

// >>> bus_master_port.sv
// Backplane master port: arbitration, direct memory transfers, interrupt vectors
`timescale 1ns/10ps
module bus_master_port #(
	parameter int NUM_DRIVES = 4,
	parameter logic [2:0] PRIO_LEVEL = bus_port_pkg::PRIO_DEFAULT
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Tape-side transfer requests
	input wire logic req_valid,
	output logic req_ready,
	input wire bus_port_pkg::xfer_req_t req,
	output logic rd_valid,
	output logic [bus_port_pkg::DATA_W-1:0] rd_data,
	output logic xfer_err,
	// Tape-side events
	input wire bus_port_pkg::event_t evt,
	// Straps
	input wire logic alt_vec_sel,
	input wire logic [8:0] drive_vec_sw [1:4],
	// Arbitration lines
	output logic npr_b_o,
	output logic npr_b_oe,
	output logic [7:4] br_b_o,
	output logic [7:4] br_b_oe,
	input wire logic npg_i,
	input wire logic [7:4] bg_i,
	output logic sack_b_o,
	output logic sack_b_oe,
	input wire logic bbsy_b_i,
	output logic bbsy_b_o,
	output logic bbsy_b_oe,
	output logic intr_b_o,
	output logic intr_b_oe,
	// Transfer lines
	output logic msyn_b_o,
	output logic msyn_b_oe,
	input wire logic ssyn_b_i,
	output logic [1:0] ctl_b_o,
	output logic [1:0] ctl_b_oe,
	output logic [bus_port_pkg::ADDR_W-1:0] addr_b_o,
	output logic addr_b_oe,
	input wire logic [bus_port_pkg::DATA_W-1:0] data_b_i,
	output logic [bus_port_pkg::DATA_W-1:0] data_b_o,
	output logic data_b_oe
);
	initial
	begin
		if (NUM_DRIVES < 1 || NUM_DRIVES > 4 || PRIO_LEVEL < 3'h4)
			$error("bus_master_port: unsupported drive count or priority level");
	end

	typedef enum logic [3:0] {
		IDLE, REQ, ACK, WAIT_FREE, SETTLE, SYNC, HOLD, DESKEW, RELEASE
	} state_t;

	state_t state_r;
	logic [6:0] cnt_r;
	logic [8:0] tmo_r;
	logic is_intr_r;
	logic [8:0] vec_r;
	logic [3:0] pend_r;
	logic [3:0] pend_clr;
	logic [3:0] pend_set;
	logic [1:0] vec_sel_r;
	logic [1:0] pick;
	bus_port_pkg::xfer_req_t cur_r;
	logic f_valid;
	logic f_take;
	bus_port_pkg::xfer_req_t f_data;
	logic npg_s1, npg_s2, bbsy_s1, bbsy_s2, ssyn_s1, ssyn_s2;
	logic [7:4] bg_s1, bg_s2;
	logic [15:0] din_s1, din_s2;
	logic grant;

	// Transfers queue here so the tape side can run ahead of arbitration
	word_fifo #(.WIDTH($bits(bus_port_pkg::xfer_req_t)), .DEPTH(bus_port_pkg::FIFO_DEPTH)) q (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(req_valid),
		.in_ready(req_ready),
		.in_data(req),
		.out_valid(f_valid),
		.out_ready(f_take),
		.out_data(f_data)
	);

	// Two-stage synchronisers on every asynchronous backplane input
	always_ff @(posedge clk)
	begin
		npg_s1 <= npg_i;
		npg_s2 <= npg_s1;
		bg_s1 <= bg_i;
		bg_s2 <= bg_s1;
		bbsy_s1 <= !bbsy_b_i;
		bbsy_s2 <= bbsy_s1;
		ssyn_s1 <= !ssyn_b_i;
		ssyn_s2 <= ssyn_s1;
		din_s1 <= ~data_b_i;
		din_s2 <= din_s1;
	end

	function automatic logic [8:0] drive_vector(input logic [1:0] d);
		if (d == 2'h0)
			return alt_vec_sel ? bus_port_pkg::VEC_FIRST_ALT : bus_port_pkg::VEC_FIRST; // [RULE7]
		return drive_vec_sw[int'(d)]; // [RULE8]
	endfunction

	always_comb
	begin
		pick = 2'h0;
		for (int i = 3; i >= 0; i--)
			if (pend_r[i])
				pick = 2'(i);
	end

	assign grant = is_intr_r ? bg_s2[PRIO_LEVEL] : npg_s2;
	assign f_take = (state_r == IDLE) && f_valid && (pend_r == 4'h0);

	assign pend_clr = (state_r == RELEASE && is_intr_r) ? 4'(4'h1 << vec_sel_r) : 4'h0;
	assign pend_set = ((evt.done || evt.error) && int'(evt.drive) < NUM_DRIVES)
		? 4'(4'h1 << evt.drive) : 4'h0; // [RULE10]

	// Events stick until their interrupt tenure reaches RELEASE, answered or timed out; a new event beats the clear
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			pend_r <= 4'h0;
		else
			pend_r <= (pend_r & ~pend_clr) | pend_set; // [RULE10]
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			state_r <= IDLE;
			is_intr_r <= 1'b0;
			vec_sel_r <= 2'h0;
			vec_r <= 9'h000;
			cur_r <= '0;
			cnt_r <= 7'h00;
			tmo_r <= 9'h000;
		end
		else
		begin
			unique case (state_r)
				IDLE:
					if (pend_r != 4'h0)
					begin
						is_intr_r <= 1'b1;
						vec_sel_r <= pick;
						vec_r <= drive_vector(pick);
						state_r <= REQ;
					end
					else if (f_valid)
					begin
						is_intr_r <= 1'b0;
						cur_r <= f_data;
						state_r <= REQ;
					end
				REQ:
					if (grant)
						state_r <= ACK; // [RULE6]
				ACK:
					if (!grant)
						state_r <= WAIT_FREE;
				WAIT_FREE:
					if (!bbsy_s2 && !ssyn_s2)
					begin
						cnt_r <= 7'(bus_port_pkg::SETTLE_CYC);
						state_r <= SETTLE; // [RULE3]
					end
				SETTLE:
					if (cnt_r == 7'h00)
					begin
						tmo_r <= 9'(bus_port_pkg::SYNC_TIMEOUT_CYC);
						state_r <= SYNC;
					end
					else
						cnt_r <= cnt_r - 7'h01;
				SYNC:
					if (ssyn_s2)
						state_r <= HOLD; // [RULE12]
					else if (tmo_r == 9'h000)
						state_r <= RELEASE;
					else
						tmo_r <= tmo_r - 9'h001;
				HOLD:
					state_r <= DESKEW;
				DESKEW:
					if (!ssyn_s2)
						state_r <= RELEASE;
				RELEASE:
					state_r <= IDLE;
				default:
					state_r <= IDLE;
			endcase
		end
	end

	// Read data captured on slave reply; timeouts flag an error pulse
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rd_valid <= 1'b0;
			rd_data <= '0;
			xfer_err <= 1'b0;
		end
		else
		begin
			rd_valid <= state_r == SYNC && ssyn_s2 && !is_intr_r
				&& cur_r.xfer == bus_port_pkg::XFER_READ;
			if (state_r == SYNC && ssyn_s2)
				rd_data <= din_s2;
			xfer_err <= state_r == SYNC && !ssyn_s2 && tmo_r == 9'h000;
		end
	end

	// Line drivers: low-active outputs, enable low means driving
	logic own;
	logic drive_data;
	assign own = state_r inside {SETTLE, SYNC, HOLD, DESKEW, RELEASE};
	assign drive_data = own && (is_intr_r || cur_r.xfer != bus_port_pkg::XFER_READ);

	always_comb
	begin
		npr_b_o = 1'b0;
		npr_b_oe = !(state_r == REQ && !is_intr_r); // [RULE4] [RULE15] [RULE14]
		br_b_o = 4'h0;
		br_b_oe = 4'hf;
		br_b_oe[PRIO_LEVEL] = !(state_r == REQ && is_intr_r); // [RULE9]
		sack_b_o = 1'b0;
		sack_b_oe = !(state_r inside {ACK, WAIT_FREE}); // [RULE6] [RULE15]
		bbsy_b_o = 1'b0;
		bbsy_b_oe = !own; // [RULE2]
		intr_b_o = 1'b0;
		intr_b_oe = !(is_intr_r && state_r inside {SYNC, HOLD}); // [RULE5]
		msyn_b_o = 1'b0;
		msyn_b_oe = !(!is_intr_r && state_r inside {SYNC, HOLD}); // [RULE11]
		ctl_b_o = ~cur_r.xfer; // [RULE1]
		ctl_b_oe = {2{!(own && !is_intr_r)}};
		addr_b_o = ~cur_r.addr; // [RULE13]
		addr_b_oe = !(own && !is_intr_r);
		data_b_o = is_intr_r ? ~{7'h00, vec_r} : ~cur_r.data; // [RULE5]
		data_b_oe = !drive_data;
	end
endmodule

// >>> bus_port_monitor.sv
// Protocol checker for the backplane master port
`timescale 1ns/10ps
module bus_port_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Watched lines
	input wire logic npr_b_oe,
	input wire logic [7:4] br_b_oe,
	input wire logic npg_i,
	input wire logic [7:4] bg_i,
	input wire logic sack_b_oe,
	input wire logic bbsy_b_i,
	input wire logic bbsy_b_oe,
	input wire logic intr_b_oe,
	input wire logic msyn_b_oe,
	input wire logic ssyn_b_i,
	input wire logic [1:0] ctl_b_o,
	input wire logic addr_b_oe,
	input wire logic data_b_oe,
	input wire logic rd_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_intr_owner: assert property (!intr_b_oe |-> !bbsy_b_oe && !data_b_oe)
		else $error("intr off bus");
	chk_msyn_hold: assert property (!msyn_b_oe |-> !bbsy_b_oe && !addr_b_oe && ctl_b_o != 2'h2)
		else $error("msyn without bus");
	chk_sack_req: assert property (!sack_b_oe |-> npr_b_oe && &br_b_oe)
		else $error("request with sack");
	chk_bbsy_sack: assert property (!bbsy_b_oe |-> sack_b_oe)
		else $error("sack with bbsy");
	chk_bus_free: assert property ($fell(bbsy_b_oe) |-> $past(bbsy_b_i) && $past(ssyn_b_i))
		else $error("bus taken early");
	chk_grant_sack: assert property ($rose(npg_i || bg_i[5]) |-> ##[1:4] !sack_b_oe)
		else $error("no sack");
	chk_br_level: assert property (&{br_b_oe[7:6], br_b_oe[4]})
		else $error("wrong level");
	chk_rd_after: assert property (rd_valid |-> !$past(msyn_b_oe) && $past(ctl_b_o) == 2'h3)
		else $error("stray read");
	cover property (!intr_b_oe);
	cover property (rd_valid);
	cover property ($fell(bbsy_b_oe));
endmodule
bind bus_master_port bus_port_monitor mon_u (.*);

// >>> backplane_model.sv
// Backplane model: arbiter, processor tenure and memory slave
`timescale 1ns/10ps
module backplane_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// From the port
	input wire logic npr_b_oe,
	input wire logic [7:4] br_b_oe,
	input wire logic sack_b_oe,
	input wire logic bbsy_b_oe,
	input wire logic msyn_b_oe,
	input wire logic intr_b_oe,
	input wire logic [1:0] ctl_b_o,
	input wire logic [17:0] addr_b_o,
	input wire logic [15:0] data_b_o,
	input wire logic data_b_oe,
	input wire logic slow,
	input wire logic mute,
	// To the port
	output logic npg_i,
	output logic [7:4] bg_i,
	output logic bbsy_b_i,
	output logic ssyn_b_i,
	output logic [15:0] data_b_i,
	output logic [35:0] seen,
	output int n_done
);
	logic ssyn_r;
	logic [3:0] hold_r;
	logic [4:0] w_r;
	wire logic strobe = !msyn_b_oe || !intr_b_oe;
	// A muted slave never answers, so the port must give up on its own
	wire logic go = strobe && !mute && w_r >= (slow ? 5'h14 : 5'h2);
	wire logic rd = ssyn_r && !msyn_b_oe && ctl_b_o == 2'h3;
	// Released lines sit at the terminator level, high
	assign bbsy_b_i = bbsy_b_oe && hold_r == 4'h0;
	assign ssyn_b_i = !ssyn_r;
	assign data_b_i = (data_b_oe ? 16'hffff : data_b_o) & (rd ? addr_b_o[15:0] ^ 16'h5a5a : 16'hffff);
	always_ff @(posedge clk)
	begin
		npg_i <= rst_b && sack_b_oe && (npg_i || !npr_b_oe);
		bg_i <= rst_b && sack_b_oe ? bg_i | ~br_b_oe : 4'h0;
		// Processor keeps the bus a while so the port must wait for bbsy
		if (!rst_b)
			hold_r <= 4'h0;
		else if (hold_r != 4'h0)
			hold_r <= hold_r - 4'h1;
		else if (!npg_i && bg_i == 4'h0 && !(npr_b_oe && &br_b_oe))
			hold_r <= 4'h6;
		w_r <= strobe && rst_b ? w_r + {4'h0, ~&w_r} : 5'h0;
		ssyn_r <= rst_b && go;
		if (!rst_b)
			n_done <= 0;
		else if (go && !ssyn_r)
			n_done <= n_done + 1;
		if (go && !ssyn_r)
			seen <= {~addr_b_o, ~data_b_o, ~ctl_b_o};
	end
endmodule

// >>> testbench.sv
// Self-checking bench for the backplane master port
`timescale 1ns/10ps
module testbench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic req_valid = 1'b0;
	bus_port_pkg::xfer_req_t req = '0;
	bus_port_pkg::event_t evt = '0;
	logic alt_vec_sel = 1'b0;
	logic [8:0] drive_vec_sw [1:4] = '{9'h0c0, 9'h0c4, 9'h0c8, 9'h0cc};
	logic slow = 1'b0;
	logic mute = 1'b0;
	int n_err = 0;
	logic req_ready, rd_valid, xfer_err, npr_b_o, npr_b_oe, sack_b_o, sack_b_oe;
	logic bbsy_b_o, bbsy_b_oe, intr_b_o, intr_b_oe, msyn_b_o, msyn_b_oe, addr_b_oe;
	logic npg_i, bbsy_b_i, ssyn_b_i, data_b_oe;
	logic [7:4] br_b_o, br_b_oe, bg_i;
	logic [1:0] ctl_b_o, ctl_b_oe;
	logic [17:0] addr_b_o;
	logic [15:0] rd_data, data_b_o, data_b_i, rd_last;
	logic [35:0] seen;
	int n_done, fail_count = 0, n_tests = 0, cyc = 0;
	bus_master_port dut_u (.*);
	backplane_model pm_u (.*);
	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (rd_valid === 1'b1)
			rd_last <= rd_data;
		if (xfer_err === 1'b1)
			n_err <= n_err + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			complete_run();
		end
	end
	task automatic cmp(input string nm, input logic [35:0] e, input logic [35:0] g);
		n_tests++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic push(input logic [1:0] x, input logic [17:0] a, input logic [15:0] d);
		req = '{addr: a, data: d, xfer: x};
		req_valid = 1'b1;
		do @(posedge clk); while (req_ready !== 1'b1);
		#2;
	endtask
	// Bounded wait for the tenure to finish and the bus to go idle
	task automatic settle(input int n0, input string nm);
		int k = 0;
		while ((n_done <= n0 || bbsy_b_oe !== 1'b1) && k < 900)
		begin
			@(posedge clk);
			k++;
		end
		repeat (4) @(posedge clk);
		if (k >= 900)
		begin
			fail_count++;
			$display("ERROR %s tenure expected done seen timeout", nm);
		end
		#2 $display("test %s ended", nm);
	endtask
	task automatic t_xfer(input logic [1:0] x, input logic [17:0] a, input logic [15:0] d);
		int n0 = n_done;
		push(x, a, d);
		req_valid = 1'b0;
		settle(n0, "xfer");
		cmp("addr", 36'(a), 36'(seen[35:18]));
		cmp("ctl", 36'(x), 36'(seen[1:0]));
		if (x == bus_port_pkg::XFER_READ)
			cmp("rdata", 36'(a[15:0] ^ 16'h5a5a), 36'(rd_last));
		else
			cmp("wdata", 36'(d), 36'(seen[17:2]));
	endtask
	task automatic t_burst;
		int n0 = n_done;
		push(bus_port_pkg::XFER_WRITE, 18'h3fffe, 16'h0001);
		push(bus_port_pkg::XFER_WRITE, 18'h00002, 16'h8000);
		push(bus_port_pkg::XFER_WRITE_BYTE, 18'h20001, 16'h00ff);
		req_valid = 1'b0;
		settle(n0 + 2, "burst");
		cmp("count", 36'h3, 36'(n_done - n0));
		cmp("last", 36'h8000403ff, seen);
	endtask
	// A silent slave must end the tenure with one error pulse and no data
	task automatic t_mute;
		int n0 = n_done;
		int e0 = n_err;
		int k = 0;
		mute = 1'b1;
		push(bus_port_pkg::XFER_READ, 18'h00400, 16'h0000);
		req_valid = 1'b0;
		while ((n_err == e0 || bbsy_b_oe !== 1'b1) && k < 600)
		begin
			@(posedge clk);
			k++;
		end
		repeat (4) @(posedge clk);
		#2 mute = 1'b0;
		cmp("xfer_err", 36'h1, 36'(n_err - e0));
		cmp("replies", 36'(n0), 36'(n_done));
		$display("test mute ended");
	endtask
	task automatic t_irq(input logic alt, input logic [1:0] dr, input logic er, input logic [8:0] v);
		int n0 = n_done;
		alt_vec_sel = alt;
		evt = '{done: !er, error: er, drive: dr};
		@(posedge clk);
		#2 evt = '0;
		settle(n0, "irq");
		cmp("vector", 36'(v), 36'(seen[17:2]));
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		#2 rst_b = 1'b1;
		t_xfer(bus_port_pkg::XFER_READ, 18'h1a5c3, 16'h0000);
		t_xfer(bus_port_pkg::XFER_WRITE, 18'h0f00e, 16'hc3a5);
		t_xfer(bus_port_pkg::XFER_WRITE_BYTE, 18'h00101, 16'h005a);
		slow = 1'b1;
		t_xfer(bus_port_pkg::XFER_READ, 18'h3ffff, 16'h0000);
		slow = 1'b0;
		t_burst();
		t_irq(1'b0, 2'h0, 1'b0, bus_port_pkg::VEC_FIRST);
		t_irq(1'b1, 2'h0, 1'b1, bus_port_pkg::VEC_FIRST_ALT);
		t_irq(1'b0, 2'h2, 1'b1, 9'h0c4);
		t_mute();
		complete_run();
	end
endmodule
